// File: src/awd_pkg.sv
// Package with register map, field positions and reset values of the window detector
package awd_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int unsigned AWD_ADDR_W  = 8;    // Byte address width of the slave
  localparam int unsigned AWD_DATA_W  = 32;   // Bus data width
  localparam int unsigned AWD_RES_W   = 10;   // Converter result width
  localparam int unsigned AWD_WORD_W  = 16;   // Result and limit word width

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] AWD_OFS_CTRL     = 8'h00;  // converter_control_reg
  localparam logic [7:0] AWD_OFS_PAIRCFG  = 8'h04;  // input_pair_config
  localparam logic [7:0] AWD_OFS_UPPER_HI = 8'h08;  // upper_compare_high_byte
  localparam logic [7:0] AWD_OFS_UPPER_LO = 8'h0c;  // upper_compare_low_byte
  localparam logic [7:0] AWD_OFS_LOWER_HI = 8'h10;  // lower_compare_high_byte
  localparam logic [7:0] AWD_OFS_LOWER_LO = 8'h14;  // lower_compare_low_byte
  localparam logic [7:0] AWD_OFS_RESULT   = 8'h18;  // result high and low bytes
  localparam logic [7:0] AWD_OFS_IRQSTAT  = 8'h1c;  // Sticky event status
  localparam logic [7:0] AWD_OFS_IRQMASK  = 8'h20;  // Event mask

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned AWD_BIT_LJST  = 0;  // left_justify_select in control
  localparam int unsigned AWD_BIT_WFLAG = 1;  // window_match_flag in control
  localparam int unsigned AWD_EV_WIN    = 0;  // Window match event in status/mask
  localparam int unsigned AWD_EV_CONV   = 1;  // Conversion complete event
  localparam int unsigned AWD_PAD_W     = 6;  // Unused bits beside a 10-bit result

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] AWD_RST_CTRL     = 8'h00;
  localparam logic [3:0] AWD_RST_PAIRCFG  = 4'h0;
  localparam logic [7:0] AWD_RST_UPPER_HI = 8'hff;
  localparam logic [7:0] AWD_RST_UPPER_LO = 8'hff;
  localparam logic [7:0] AWD_RST_LOWER_HI = 8'h00;
  localparam logic [7:0] AWD_RST_LOWER_LO = 8'h00;
  localparam logic [1:0] AWD_RST_IRQMASK  = 2'h0;

  // ==========================================================================
  // Bus responses
  // ==========================================================================
  localparam logic [1:0] AWD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AWD_RESP_SLVERR = 2'h2;

endpackage : awd_pkg

// File: src/awd_window_cmp.sv
// Signed or unsigned window comparison of one result word against two limits
`timescale 1ns/1ps

module awd_window_cmp
  import awd_pkg::*;
(
  input  wire logic [AWD_WORD_W-1:0] sample,      // Result word in register alignment
  input  wire logic [AWD_WORD_W-1:0] gtLimit,     // greater_than_limit
  input  wire logic [AWD_WORD_W-1:0] ltLimit,     // less_than_limit
  input  wire logic                  signedMode,  // Two's complement compare
  output logic                       insideMode,  // Window is inside form
  output logic                       winMatch     // Condition met for this sample
);

  // ==========================================================================
  // Extended operands
  // ==========================================================================
  logic signed [AWD_WORD_W:0] sExt;   // Sample with one guard bit
  logic signed [AWD_WORD_W:0] gExt;   // Upper limit with guard bit
  logic signed [AWD_WORD_W:0] lExt;   // Lower limit with guard bit

  // Guard bit copies the sign only in signed mode, so one compare serves both
  always_comb begin
    sExt = {signedMode & sample[AWD_WORD_W-1], sample};
    gExt = {signedMode & gtLimit[AWD_WORD_W-1], gtLimit};
    lExt = {signedMode & ltLimit[AWD_WORD_W-1], ltLimit};
  end

  // Limit order alone picks inside or outside; equality never matches
  always_comb begin
    insideMode = lExt > gExt;
    if (insideMode) begin
      winMatch = (sExt > gExt) && (sExt < lExt);
    end else begin
      winMatch = (sExt < lExt) || (sExt > gExt);
    end
  end

endmodule : awd_window_cmp

// File: src/awd_window_detector.sv
// Window detector on the converter result path with an AXI4-Lite register slave
//
// Contract
// - Compare every new result against both limits.
// - Match flag lives in control register.
// - Two limit pairs, each high and low byte.
// - Limit order alone selects inside or outside.
// - Single-ended compare is unsigned.
// - Inside matches strictly between both limits.
// - Outside matches strictly beyond either limit.
// - Differential result is two's complement.
// - Differential inside compare is signed.
// - Differential outside compare is signed.
// - Compare in the result register alignment; single-ended right form compares the code zero-extended, not sign-extended.
// - Flag stays set until software clears.
// - Justify bit aligns; right form sign-extends.
// - Differential pairs give two's complement results.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module awd_window_detector
  import awd_pkg::*;
(
  input  wire logic                  clk,          // System clock, 100 MHz
  input  wire logic                  rst,          // Synchronous reset, active high
  // Converter result path
  input  wire logic                  convDone,     // One-cycle pulse, new result ready
  input  wire logic [AWD_RES_W-1:0]  convData,     // Raw 10-bit conversion code
  input  wire logic [3:0]            convChannel,  // Multiplexer channel of that result
  // AXI4-Lite slave
  input  wire logic [AWD_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [AWD_DATA_W-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AWD_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [AWD_DATA_W-1:0]      rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // System side
  output logic                       irq           // Level interrupt
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic                  leftJust;       // left_justify_select
  logic                  matchFlag;      // window_match_flag
  logic [3:0]            pairCfg;        // input_pair_config
  logic [7:0]            upperHi;        // upper_compare_high_byte
  logic [7:0]            upperLo;        // upper_compare_low_byte
  logic [7:0]            lowerHi;        // lower_compare_high_byte
  logic [7:0]            lowerLo;        // lower_compare_low_byte
  logic [AWD_WORD_W-1:0] resultWord;     // result_high_byte and result_low_byte
  logic [1:0]            irqStatus;      // Sticky events
  logic [1:0]            irqMask;        // Event enables
  logic                  next_leftJust;
  logic                  next_matchFlag;
  logic [3:0]            next_pairCfg;
  logic [7:0]            next_upperHi;
  logic [7:0]            next_upperLo;
  logic [7:0]            next_lowerHi;
  logic [7:0]            next_lowerLo;
  logic [AWD_WORD_W-1:0] next_resultWord;
  logic [1:0]            next_irqStatus;
  logic [1:0]            next_irqMask;

  // ==========================================================================
  // Bus handshake state
  // ==========================================================================
  logic                  awPend;         // Write address held
  logic [AWD_ADDR_W-1:0] awHeld;         // Held write address
  logic                  wPend;          // Write data held
  logic [AWD_DATA_W-1:0] wHeld;          // Held write data
  logic [3:0]            strbHeld;       // Held byte strobes
  logic                  next_awPend;
  logic [AWD_ADDR_W-1:0] next_awHeld;
  logic                  next_wPend;
  logic [AWD_DATA_W-1:0] next_wHeld;
  logic [3:0]            next_strbHeld;
  logic [1:0]            next_bresp;
  logic                  next_bvalid;
  logic [AWD_DATA_W-1:0] next_rdata;
  logic [1:0]            next_rresp;
  logic                  next_rvalid;

  // ==========================================================================
  // Result formatting and comparison
  // ==========================================================================
  logic                  diffMode;       // Current result is differential
  logic [AWD_WORD_W-1:0] fmtWord;        // Result as the register shows it
  logic [AWD_WORD_W-1:0] cmpWord;        // Result as the comparator sees it
  logic                  insideMode;     // Limits describe an inside window
  logic                  winMatch;       // New result meets the window
  logic                  doWrite;        // Held write is carried out now
  logic                  arHs;           // Read address taken now
  logic                  byte0;          // Low byte lane written
  logic                  statusRead;     // Read of the status register now

  // Pair bit picked by channel; temperature channel is always single-ended
  always_comb begin
    diffMode = !convChannel[3] && pairCfg[convChannel[2:1]];
    if (leftJust) begin
      fmtWord = {convData, {AWD_PAD_W{1'b0}}};
      cmpWord = fmtWord;
    end else begin
      fmtWord = {{AWD_PAD_W{convData[AWD_RES_W-1]}}, convData};
      // Single-ended right form compares as plain 10-bit unsigned
      cmpWord = diffMode ? fmtWord : {{AWD_PAD_W{1'b0}}, convData};
    end
  end

  // Limits form 16-bit words from their byte pairs
  awd_window_cmp u_cmp (
    .sample     (cmpWord),
    .gtLimit    ({upperHi, upperLo}),
    .ltLimit    ({lowerHi, lowerLo}),
    .signedMode (diffMode),
    .insideMode (insideMode),
    .winMatch   (winMatch)
  );

  // ==========================================================================
  // Bus handshakes
  // ==========================================================================
  // Address and data are taken in either order; no new ones while a reply waits
  always_comb begin
    awready    = !awPend && !bvalid;
    wready     = !wPend && !bvalid;
    arready    = !rvalid;
    doWrite    = awPend && wPend && !bvalid;
    arHs       = arvalid && arready;
    byte0      = strbHeld[0];
    statusRead = arHs && (araddr == AWD_OFS_IRQSTAT);
  end

  // Next values of the bus channel state
  always_comb begin
    next_awPend   = awPend;
    next_awHeld   = awHeld;
    next_wPend    = wPend;
    next_wHeld    = wHeld;
    next_strbHeld = strbHeld;
    next_bresp    = bresp;
    next_bvalid   = bvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    next_rvalid   = rvalid;
    // Capture write address
    if (awvalid && awready) begin
      next_awPend = 1'b1;
      next_awHeld = awaddr;
    end
    // Capture write data
    if (wvalid && wready) begin
      next_wPend    = 1'b1;
      next_wHeld    = wdata;
      next_strbHeld = wstrb;
    end
    // Carry out write and raise the response
    if (doWrite) begin
      next_awPend = 1'b0;
      next_wPend  = 1'b0;
      next_bvalid = 1'b1;
      case (awHeld)
        AWD_OFS_CTRL, AWD_OFS_PAIRCFG, AWD_OFS_UPPER_HI, AWD_OFS_UPPER_LO,
        AWD_OFS_LOWER_HI, AWD_OFS_LOWER_LO, AWD_OFS_RESULT, AWD_OFS_IRQSTAT,
        AWD_OFS_IRQMASK: next_bresp = AWD_RESP_OKAY;
        default:         next_bresp = AWD_RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // Read data is sampled at the address handshake
    if (arHs) begin
      next_rvalid = 1'b1;
      next_rresp  = AWD_RESP_OKAY;
      case (araddr)
        AWD_OFS_CTRL:     next_rdata = {30'h0, matchFlag, leftJust};
        AWD_OFS_PAIRCFG:  next_rdata = {28'h0, pairCfg};
        AWD_OFS_UPPER_HI: next_rdata = {24'h0, upperHi};
        AWD_OFS_UPPER_LO: next_rdata = {24'h0, upperLo};
        AWD_OFS_LOWER_HI: next_rdata = {24'h0, lowerHi};
        AWD_OFS_LOWER_LO: next_rdata = {24'h0, lowerLo};
        AWD_OFS_RESULT:   next_rdata = {16'h0, resultWord};
        AWD_OFS_IRQSTAT:  next_rdata = {30'h0, irqStatus};
        AWD_OFS_IRQMASK:  next_rdata = {30'h0, irqMask};
        default: begin
          next_rdata = 32'h0;
          next_rresp = AWD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Register bus channel state
  always_ff @(posedge clk) begin
    if (rst) begin
      awPend   <= 1'b0;
      awHeld   <= 8'h00;
      wPend    <= 1'b0;
      wHeld    <= 32'h0;
      strbHeld <= 4'h0;
      bresp    <= AWD_RESP_OKAY;
      bvalid   <= 1'b0;
      rdata    <= 32'h0;
      rresp    <= AWD_RESP_OKAY;
      rvalid   <= 1'b0;
    end else begin
      awPend   <= next_awPend;
      awHeld   <= next_awHeld;
      wPend    <= next_wPend;
      wHeld    <= next_wHeld;
      strbHeld <= next_strbHeld;
      bresp    <= next_bresp;
      bvalid   <= next_bvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      rvalid   <= next_rvalid;
    end
  end

  // ==========================================================================
  // Registers, match flag and events
  // ==========================================================================
  // Software writes first, hardware sets last so a set is never lost
  always_comb begin
    next_leftJust   = leftJust;
    next_matchFlag  = matchFlag;
    next_pairCfg    = pairCfg;
    next_upperHi    = upperHi;
    next_upperLo    = upperLo;
    next_lowerHi    = lowerHi;
    next_lowerLo    = lowerLo;
    next_resultWord = resultWord;
    next_irqStatus  = irqStatus;
    next_irqMask    = irqMask;
    // Byte-wide writes; every limit byte stands alone
    if (doWrite && byte0) begin
      case (awHeld)
        AWD_OFS_CTRL: begin
          next_leftJust  = wHeld[AWD_BIT_LJST];
          next_matchFlag = wHeld[AWD_BIT_WFLAG];
        end
        AWD_OFS_PAIRCFG:  next_pairCfg = wHeld[3:0];
        AWD_OFS_UPPER_HI: next_upperHi = wHeld[7:0];
        AWD_OFS_UPPER_LO: next_upperLo = wHeld[7:0];
        AWD_OFS_LOWER_HI: next_lowerHi = wHeld[7:0];
        AWD_OFS_LOWER_LO: next_lowerLo = wHeld[7:0];
        AWD_OFS_IRQMASK:  next_irqMask = wHeld[1:0];
        default:          next_irqMask = irqMask;
      endcase
    end
    // Reading the status clears it
    if (statusRead) begin
      next_irqStatus = 2'h0;
    end
    // One evaluation per completed conversion
    if (convDone) begin
      next_resultWord = fmtWord;
      next_irqStatus[AWD_EV_CONV] = 1'b1;
      if (winMatch) begin
        next_matchFlag = 1'b1;
        next_irqStatus[AWD_EV_WIN] = 1'b1;
      end
    end
  end

  // Register file
  always_ff @(posedge clk) begin
    if (rst) begin
      leftJust   <= AWD_RST_CTRL[AWD_BIT_LJST];
      matchFlag  <= AWD_RST_CTRL[AWD_BIT_WFLAG];
      pairCfg    <= AWD_RST_PAIRCFG;
      upperHi    <= AWD_RST_UPPER_HI;
      upperLo    <= AWD_RST_UPPER_LO;
      lowerHi    <= AWD_RST_LOWER_HI;
      lowerLo    <= AWD_RST_LOWER_LO;
      resultWord <= 16'h0;
      irqStatus  <= 2'h0;
      irqMask    <= AWD_RST_IRQMASK;
    end else begin
      leftJust   <= next_leftJust;
      matchFlag  <= next_matchFlag;
      pairCfg    <= next_pairCfg;
      upperHi    <= next_upperHi;
      upperLo    <= next_upperLo;
      lowerHi    <= next_lowerHi;
      lowerLo    <= next_lowerLo;
      resultWord <= next_resultWord;
      irqStatus  <= next_irqStatus;
      irqMask    <= next_irqMask;
    end
  end

  // Interrupt line follows unmasked sticky bits
  always_comb begin
    irq = |(irqStatus & irqMask);
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Software write of zero to the flag bit of the control register
  logic flagClear;
  always_comb begin
    flagClear = doWrite && byte0 && (awHeld == AWD_OFS_CTRL) && !wHeld[AWD_BIT_WFLAG];
  end

  sequence s_newMatch;
    convDone && winMatch;
  endsequence

  sequence s_flagSeen;
    matchFlag && irqStatus[AWD_EV_WIN];
  endsequence

  a_match_sets_flag: assert property (s_newMatch |=> s_flagSeen)
    else $error("match did not set flag and status");
  a_flag_held: assert property (matchFlag && !flagClear |=> matchFlag)
    else $error("match flag dropped without clear");
  a_flag_cause: assert property ($rose(matchFlag) |-> $past((convDone && winMatch) ||
    (doWrite && byte0 && (awHeld == AWD_OFS_CTRL) && wHeld[AWD_BIT_WFLAG])))
    else $error("match flag rose without cause");
  a_inside_edge: assert property (convDone && insideMode &&
    (cmpWord == {upperHi, upperLo}) |-> !winMatch)
    else $error("inside window matched on upper limit");
  a_outside_edge: assert property (convDone && !insideMode &&
    (cmpWord == {lowerHi, lowerLo}) |-> !winMatch)
    else $error("outside window matched on lower limit");
  a_sign_extend: assert property (convDone && !leftJust |=>
    resultWord[15:10] == {AWD_PAD_W{resultWord[9]}})
    else $error("right form not sign extended");
  a_left_align: assert property (convDone && leftJust |=>
    resultWord == {$past(convData), 6'h00})
    else $error("left form misaligned");
  a_limit_flag: assert property (matchFlag && doWrite &&
    (awHeld != AWD_OFS_CTRL) |=> matchFlag)
    else $error("limit write cleared match flag");
  a_diff_neg: assert property (convDone && diffMode && convData[9] &&
    ({upperHi, upperLo} == 16'hffff) && !leftJust && insideMode |-> !winMatch)
    else $error("negative result matched above minus one");
  a_irq_level: assert property (convDone && winMatch && irqMask[AWD_EV_WIN] &&
    !(doWrite && (awHeld == AWD_OFS_IRQMASK)) |=> irq)
    else $error("unmasked match raised no interrupt");

endmodule : awd_window_detector

// File: verif/awd_conv_model.sv
// Behavioural model of the ten-bit converter result output
`timescale 1ns/1ps

module awd_conv_model
  import awd_pkg::*;
(
  input  wire logic                 clk,          // System clock
  output logic                      convDone,     // Result strobe
  output logic [AWD_RES_W-1:0]      convData,     // Raw result code
  output logic [3:0]                convChannel   // Channel of that result
);
  // ====================
  // Result delivery
  // ====================
  initial begin
    convDone    = 1'b0;
    convData    = '0;
    convChannel = '0;
  end

  // One-cycle strobe; data and channel turn to their inverse once it is over
  task automatic send(input logic [AWD_RES_W-1:0] d, input logic [3:0] ch);
    convDone    <= 1'b1;
    convData    <= d;
    convChannel <= ch;
    @(posedge clk);
    convDone    <= 1'b0;
    convData    <= ~d;
    convChannel <= ~ch;
  endtask : send
endmodule : awd_conv_model

// File: verif/tb.sv
// Self-checking bench of the window detector through its register bus
`timescale 1ns/1ps

module tb
  import awd_pkg::*;
;
  // ====================
  // Signals
  // ====================
  logic                  clk = 1'b0;                                    // Bench clock
  logic                  rst = 1'b1;                                    // Reset
  logic [AWD_ADDR_W-1:0] awaddr = '0, araddr = '0;                      // Addresses
  logic [AWD_DATA_W-1:0] wdata = '0, rdata, rd;                         // Data
  logic [3:0]            wstrb = '0, convChannel;                       // Strobes
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;  // Write side
  logic                  arvalid = 1'b0, rready = 1'b0, lj = 1'b0;      // Read side
  logic                  awready, wready, bvalid, arready, rvalid, irq, convDone;
  logic [1:0]            bresp, rresp, rsp;                             // Responses
  logic [AWD_RES_W-1:0]  convData;                                      // Result code
  int                    failCount = 0, cmpCount = 0;                   // Counters
  logic [7:0]            rOfs [5] = '{AWD_OFS_CTRL, AWD_OFS_UPPER_HI, AWD_OFS_UPPER_LO,
                                      AWD_OFS_LOWER_HI, AWD_OFS_LOWER_LO};
  logic [7:0]            rVal [5] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

  always #5 clk = ~clk;

  awd_conv_model conv_u (.clk, .convDone, .convData, .convChannel);
  awd_window_detector dut_u (.clk, .rst, .convDone, .convData, .convChannel, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);

  // ====================
  // Tasks
  // ====================
  // One bus write or read; each channel released at the edge that takes it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int         n;
    logic [4:0] hs;
    n = 0;
    if (w) begin
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    end else begin
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    end
    do begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        failCount++;
        conclude();
      end
      hs = {awvalid & awready, wvalid & wready, arvalid & arready, bvalid & bready,
            rvalid & rready};
      if (hs[1]) rsp = bresp;
      if (hs[0]) begin
        rd  = rdata;
        rsp = rresp;
      end
      @(posedge clk);
      if (hs[4]) awvalid <= 1'b0;
      if (hs[3]) wvalid <= 1'b0;
      if (hs[2]) arvalid <= 1'b0;
      if (hs[1]) bready <= 1'b0;
      if (hs[0]) rready <= 1'b0;
    end while (awvalid || wvalid || arvalid || bready || rready);
  endtask : bus

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      failCount++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Clear the flag, deliver one result, read the flag back
  task automatic win(input logic [9:0] d, input logic [3:0] ch, input logic e);
    bus(1'b1, AWD_OFS_CTRL, {31'h0, lj});
    conv_u.send(d, ch);
    bus(1'b0, AWD_OFS_CTRL, 32'h0);
    chk(rd, {30'h0, e, lj});
  endtask : win

  task automatic lim(input logic [15:0] up, input logic [15:0] lo);
    bus(1'b1, AWD_OFS_UPPER_HI, {24'h0, up[15:8]});
    bus(1'b1, AWD_OFS_UPPER_LO, {24'h0, up[7:0]});
    bus(1'b1, AWD_OFS_LOWER_HI, {24'h0, lo[15:8]});
    bus(1'b1, AWD_OFS_LOWER_LO, {24'h0, lo[7:0]});
  endtask : lim

  task automatic irqChk(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask : irqChk

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // ====================
  // Main sequence
  // ====================
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, rOfs[i], 32'h0);
      chk(rd, {24'h0, rVal[i]});
    end
    bus(1'b0, 8'h40, 32'h0);
    chk({30'h0, rsp}, {30'h0, AWD_RESP_SLVERR});
    chk(rd, 32'h0);
    bus(1'b1, 8'h40, 32'h3);
    chk({30'h0, rsp}, {30'h0, AWD_RESP_SLVERR});
    bus(1'b0, AWD_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    lim(16'h0040, 16'h0080);
    win(10'h040, 4'h0, 1'b0);
    win(10'h041, 4'h0, 1'b1);
    win(10'h07f, 4'h0, 1'b1);
    win(10'h080, 4'h0, 1'b0);
    lim(16'h0080, 16'h0040);
    win(10'h03f, 4'h0, 1'b1);
    win(10'h081, 4'h0, 1'b1);
    win(10'h040, 4'h0, 1'b0);
    win(10'h080, 4'h0, 1'b0);
    conv_u.send(10'h03f, 4'h0);
    @(posedge clk);
    conv_u.send(10'h060, 4'h0);
    bus(1'b0, AWD_OFS_CTRL, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, AWD_OFS_UPPER_LO, 32'h10);
    bus(1'b0, AWD_OFS_CTRL, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, AWD_OFS_PAIRCFG, 32'h1);
    lim(16'hffff, 16'h0040);
    win(10'h3ff, 4'h0, 1'b0);
    win(10'h000, 4'h0, 1'b1);
    win(10'h03f, 4'h1, 1'b1);
    win(10'h040, 4'h1, 1'b0);
    win(10'h200, 4'h0, 1'b0);
    lim(16'h0040, 16'hffff);
    win(10'h3fe, 4'h0, 1'b1);
    bus(1'b0, AWD_OFS_RESULT, 32'h0);
    chk(rd, 32'h0000fffe);
    win(10'h3ff, 4'h0, 1'b0);
    win(10'h041, 4'h1, 1'b1);
    win(10'h3ff, 4'h8, 1'b1);
    win(10'h3ff, 4'h2, 1'b1);
    lj = 1'b1;
    lim(16'h1000, 16'h2000);
    win(10'h040, 4'h2, 1'b0);
    win(10'h041, 4'h2, 1'b1);
    win(10'h080, 4'h2, 1'b0);
    bus(1'b0, AWD_OFS_RESULT, 32'h0);
    chk(rd, 32'h00002000);
    bus(1'b1, AWD_OFS_IRQMASK, 32'h1);
    chk({30'h0, rsp}, {30'h0, AWD_RESP_OKAY});
    bus(1'b0, AWD_OFS_IRQSTAT, 32'h0);
    irqChk(1'b0);
    win(10'h041, 4'h2, 1'b1);
    irqChk(1'b1);
    bus(1'b0, AWD_OFS_IRQSTAT, 32'h0);
    chk(rd, 32'h3);
    irqChk(1'b0);
    bus(1'b1, AWD_OFS_IRQMASK, 32'h0);
    win(10'h041, 4'h2, 1'b1);
    irqChk(1'b0);
    conclude();
  end
endmodule : tb
